// ### rtl/bld_engine.sv
// line draw engine: register file, bresenham walker, pixel pipeline
// assumes a frame buffer port that answers each read with fb_rd_valid
`timescale 1ns/10ps
`default_nettype none
`include "bld_params.svh"

module bld_engine (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire bld_pkg::bld_reg_req_type reg_req,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic mem_wr,
	input wire logic [19:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	output logic pix_ready,
	output bld_pkg::bld_fb_req_type fb_req,
	input wire logic fb_rd_valid,
	input wire logic [7:0] fb_rd_data,
	output logic busy
);

	typedef struct packed {
		bld_pkg::bld_regs_type r;
		bld_pkg::bld_state_type st;
		logic [15:0] cnt;
		logic [7:0] colour;
		logic [15:0] rdata;
		logic rvalid;
		bld_pkg::bld_fb_req_type fb;
		logic busy;
	} bld_eng_state_type;

	bld_eng_state_type q;
	bld_eng_state_type d;

	logic fifo_in_valid;
	logic [15:0] fifo_in_data;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [15:0] fifo_out_data;
	logic fifo_pop;
	logic win_hit;
	logic port_hit;
	logic [15:0] mix_word;
	logic [1:0] src;
	logic in_clip;
	logic clip_ok;
	logic cmp_ok;
	logic [7:0] mixed;
	logic [15:0] sx;
	logic [15:0] sy;

	// -----------------------------------------------------------------
	// mix function on one pixel
	// -----------------------------------------------------------------
	function automatic logic [7:0] mix_f(input logic [3:0] op,
		input logic [7:0] dv, input logic [7:0] nv);
		logic [7:0] res;
		res = nv;
		case (op)
			4'h0: res = ~dv;
			4'h1: res = 8'h00;
			4'h2: res = 8'hff;
			4'h3: res = dv;
			4'h4: res = ~nv;
			`BLD_MIX_XOR: res = dv ^ nv;
			4'h6: res = ~(dv ^ nv);
			`BLD_MIX_NEW: res = nv;
			4'h8: res = ~dv | ~nv;
			4'h9: res = dv | ~nv;
			4'ha: res = ~dv | nv;
			4'hb: res = dv | nv;
			4'hc: res = dv & nv;
			4'hd: res = ~dv & nv;
			4'he: res = dv & ~nv;
			4'hf: res = ~dv & ~nv;
			default: res = nv;
		endcase
		return res;
	endfunction

	// -----------------------------------------------------------------
	// cpu pixel data path
	// -----------------------------------------------------------------
	assign win_hit = mem_wr && (mem_addr >= `BLD_WIN_LO)
		&& (mem_addr <= `BLD_WIN_HI);
	assign port_hit = reg_req.wr && ((reg_req.addr == `BLD_OFF_PIX0)
		|| (reg_req.addr == `BLD_OFF_PIX1));
	// transfer port wins if both land together; the window write is dropped
	assign fifo_in_valid = port_hit || win_hit;
	assign fifo_in_data = port_hit ? reg_req.wdata[15:0] : mem_wdata;

	bld_fifo #(
		.WIDTH(`BLD_FIFO_WIDTH),
		.DEPTH(`BLD_FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.in_valid(fifo_in_valid),
		.in_data(fifo_in_data),
		.in_ready(fifo_in_ready),
		.out_valid(fifo_out_valid),
		.out_data(fifo_out_data),
		.out_ready(fifo_pop)
	);

	// -----------------------------------------------------------------
	// pixel decisions
	// -----------------------------------------------------------------
	always_comb begin
		// only pixel control A000H routes through the foreground mix
		mix_word = (q.r.pixctl == `BLD_PIXCTL_FG) ? q.r.fg_mix
			: q.r.bg_mix;
		src = mix_word[6:5];
		in_clip = (q.r.cur_x[11:0] >= q.r.clip_l)
			&& (q.r.cur_x[11:0] <= q.r.clip_r)
			&& (q.r.cur_y[11:0] >= q.r.clip_t)
			&& (q.r.cur_y[11:0] <= q.r.clip_b);
		clip_ok = q.r.misc[`BLD_MISC_EXTCLIP] ? !in_clip : in_clip;
		cmp_ok = !q.r.misc[`BLD_MISC_CMP_EN]
			|| ((fb_rd_data == q.r.cmp[7:0])
			== q.r.misc[`BLD_MISC_CMP_POL]);
		mixed = mix_f(mix_word[3:0], fb_rd_data, q.colour);
		sx = q.r.cmd[`BLD_CMD_XPOS] ? 16'h0001 : 16'hffff;
		sy = q.r.cmd[`BLD_CMD_YPOS] ? 16'h0001 : 16'hffff;
		fifo_pop = (q.st == bld_pkg::ST_COLOUR) && (src == `BLD_SRC_CPU)
			&& fifo_out_valid;
	end

	// -----------------------------------------------------------------
	// register file and walker
	// -----------------------------------------------------------------
	always_comb begin
		d = q;
		d.rvalid = 1'b0;
		d.fb.rd = 1'b0;
		d.fb.wr = 1'b0;

		// registers hold until rewritten, so draws reuse them
		if (reg_req.wr && !reg_req.wide) begin
			case (reg_req.addr)
				`BLD_OFF_CUR_Y: d.r.cur_y = reg_req.wdata[15:0];
				`BLD_OFF_CUR_X: d.r.cur_x = reg_req.wdata[15:0];
				`BLD_OFF_AXSTP: d.r.axstp = reg_req.wdata[15:0];
				`BLD_OFF_DGSTP: d.r.dgstp = reg_req.wdata[15:0];
				`BLD_OFF_ERR: d.r.err = reg_req.wdata[15:0];
				`BLD_OFF_PCNT: d.r.pcnt = reg_req.wdata[15:0];
				`BLD_OFF_BG_COL: d.r.bg_col = reg_req.wdata[15:0];
				`BLD_OFF_FG_COL: d.r.fg_col = reg_req.wdata[15:0];
				`BLD_OFF_WMASK: d.r.wmask = reg_req.wdata[15:0];
				`BLD_OFF_CMP: d.r.cmp = reg_req.wdata[15:0];
				`BLD_OFF_BG_MIX: d.r.bg_mix = reg_req.wdata[15:0];
				`BLD_OFF_FG_MIX: d.r.fg_mix = reg_req.wdata[15:0];
				`BLD_OFF_MULTI: begin
					case (reg_req.wdata[15:12])
						`BLD_IDX_TOP: d.r.clip_t = reg_req.wdata[11:0];
						`BLD_IDX_LEFT: d.r.clip_l = reg_req.wdata[11:0];
						`BLD_IDX_BOT: d.r.clip_b = reg_req.wdata[11:0];
						`BLD_IDX_RIGHT: d.r.clip_r = reg_req.wdata[11:0];
						`BLD_IDX_PIXCTL: d.r.pixctl = reg_req.wdata[11:0];
						`BLD_IDX_MISC: d.r.misc = reg_req.wdata[11:0];
						default: d.r.misc = q.r.misc;
					endcase
				end
				default: d.r = q.r;
			endcase
		end else if (reg_req.wr) begin
			case (reg_req.addr)
				`BLD_OFF_PK_POS: begin
					d.r.cur_y = reg_req.wdata[15:0];
					d.r.cur_x = reg_req.wdata[31:16];
				end
				`BLD_OFF_PK_STEP: begin
					d.r.axstp = reg_req.wdata[15:0];
					d.r.dgstp = reg_req.wdata[31:16];
				end
				`BLD_OFF_PK_MIX: begin
					d.r.bg_mix = reg_req.wdata[15:0];
					d.r.fg_mix = reg_req.wdata[31:16];
				end
				`BLD_OFF_PK_PCNT: d.r.pcnt = reg_req.wdata[31:16];
				default: d.r = q.r;
			endcase
		end

		if (reg_req.rd) begin
			d.rvalid = 1'b1;
			case (reg_req.addr)
				`BLD_OFF_CUR_Y: d.rdata = q.r.cur_y;
				`BLD_OFF_CUR_X: d.rdata = q.r.cur_x;
				`BLD_OFF_AXSTP: d.rdata = q.r.axstp;
				`BLD_OFF_DGSTP: d.rdata = q.r.dgstp;
				`BLD_OFF_ERR: d.rdata = q.r.err;
				`BLD_OFF_PCNT: d.rdata = q.r.pcnt;
				`BLD_OFF_CMD: d.rdata = 16'(q.busy) << `BLD_STAT_BUSY;
				`BLD_OFF_BG_COL: d.rdata = q.r.bg_col;
				`BLD_OFF_FG_COL: d.rdata = q.r.fg_col;
				`BLD_OFF_WMASK: d.rdata = q.r.wmask;
				`BLD_OFF_CMP: d.rdata = q.r.cmp;
				`BLD_OFF_BG_MIX: d.rdata = q.r.bg_mix;
				`BLD_OFF_FG_MIX: d.rdata = q.r.fg_mix;
				default: d.rdata = 16'h0000;
			endcase
		end

		case (q.st)
			bld_pkg::ST_IDLE: begin
				// a command arriving while busy is ignored
				if (reg_req.wr && !reg_req.wide
					&& reg_req.addr == `BLD_OFF_CMD) begin
					d.r.cmd = reg_req.wdata[15:0];
					if ({reg_req.wdata[15:13], reg_req.wdata[11]}
						== `BLD_CMD_OP_LINE && reg_req.wdata[0]) begin
						d.cnt = q.r.pcnt;
						d.busy = 1'b1;
						d.st = reg_req.wdata[`BLD_CMD_DRAW]
							? bld_pkg::ST_COLOUR : bld_pkg::ST_STEP;
					end
				end
			end
			bld_pkg::ST_COLOUR: begin
				if (src == `BLD_SRC_CPU) begin
					// stalls here until cpu data arrives
					if (fifo_out_valid) begin
						d.colour = fifo_out_data[7:0];
						d.st = clip_ok ? bld_pkg::ST_READ : bld_pkg::ST_STEP;
					end
				end else begin
					d.colour = (src == `BLD_SRC_BG) ? q.r.bg_col[7:0]
						: q.r.fg_col[7:0];
					d.st = clip_ok ? bld_pkg::ST_READ : bld_pkg::ST_STEP;
				end
			end
			bld_pkg::ST_READ: begin
				d.fb.rd = 1'b1;
				d.fb.x = q.r.cur_x;
				d.fb.y = q.r.cur_y;
				d.st = bld_pkg::ST_WAIT;
			end
			bld_pkg::ST_WAIT: begin
				if (fb_rd_valid) begin
					d.fb.wr = cmp_ok;
					// masked planes carry the old value back unchanged
					d.fb.data = (mixed & q.r.wmask[7:0])
						| (fb_rd_data & ~q.r.wmask[7:0]);
					d.fb.mask = q.r.wmask[7:0];
					d.st = bld_pkg::ST_STEP;
				end
			end
			bld_pkg::ST_STEP: begin
				if (q.cnt == 16'h0000) begin
					d.busy = 1'b0;
					d.st = bld_pkg::ST_IDLE;
				end else begin
					d.cnt = q.cnt - 16'h0001;
					if (!q.r.err[15]) begin
						d.r.cur_x = q.r.cur_x + sx;
						d.r.cur_y = q.r.cur_y + sy;
						d.r.err = q.r.err + q.r.dgstp;
					end else begin
						if (q.r.cmd[`BLD_CMD_YMAJ]) begin
							d.r.cur_y = q.r.cur_y + sy;
						end else begin
							d.r.cur_x = q.r.cur_x + sx;
						end
						d.r.err = q.r.err + q.r.axstp;
					end
					d.st = q.r.cmd[`BLD_CMD_DRAW] ? bld_pkg::ST_COLOUR
						: bld_pkg::ST_STEP;
				end
			end
			default: d.st = bld_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			q <= '0;
			q.r.wmask <= `BLD_RST_WMASK;
			q.r.fg_mix <= `BLD_RST_MIX;
			q.r.bg_mix <= `BLD_RST_MIX;
			q.r.clip_b <= `BLD_RST_CLIP_MAX;
			q.r.clip_r <= `BLD_RST_CLIP_MAX;
			q.st <= bld_pkg::ST_IDLE;
		end else if (ce) begin
			q <= d;
		end
	end

	assign reg_rdata = q.rdata;
	assign reg_rvalid = q.rvalid;
	assign fb_req = q.fb;
	assign busy = q.busy;
	assign pix_ready = fifo_in_ready;

endmodule
`default_nettype wire

// ### pkg/bld_params.svh
// constants for the line draw engine: offsets, fields, resets, counts
// assumes inclusion by the design, checker and bench files by bare name
//
// Overview of operation
// - pixel control A000H makes the foreground mix govern every pixel.
// - mix code 00111b replaces the destination pixel with the new colour.
// - mix code 00101b writes destination XOR new colour.
// - command bit 7 set steps Y upward, cleared steps Y downward.
// - command bit 6 set makes Y the major axis, cleared makes X.
// - command bit 5 set steps X upward, cleared steps X downward.
// - op bits 15-13 and 11 mean line, bit 4 draws, bit 0 one.
// - every update is gated by four clip bounds and inside/outside choice.
// - colour compare acts only with index E bit 8 set.
// - index E bit 7 picks whether true or false compare allows writing.
// - only planes enabled in the write mask change.
// - cpu pixel data enters via two transfer ports or the A0000H window.
// - colour, mix and extension settings persist across commands.
// - packed 32-bit position write: Y in low half, X in high half.
`ifndef BLD_PARAMS_SVH
`define BLD_PARAMS_SVH

// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define BLD_OFF_CUR_Y 16'h82e8
`define BLD_OFF_CUR_X 16'h86e8
`define BLD_OFF_AXSTP 16'h8ae8
`define BLD_OFF_DGSTP 16'h8ee8
`define BLD_OFF_ERR 16'h92e8
`define BLD_OFF_PCNT 16'h96e8
`define BLD_OFF_CMD 16'h9ae8
`define BLD_OFF_BG_COL 16'ha2e8
`define BLD_OFF_FG_COL 16'ha6e8
`define BLD_OFF_WMASK 16'haae8
`define BLD_OFF_CMP 16'hb2e8
`define BLD_OFF_BG_MIX 16'hb6e8
`define BLD_OFF_FG_MIX 16'hbae8
`define BLD_OFF_MULTI 16'hbee8
`define BLD_OFF_PIX0 16'he2e8
`define BLD_OFF_PIX1 16'he2ea
`define BLD_OFF_PK_POS 16'h8100
`define BLD_OFF_PK_STEP 16'h8108
`define BLD_OFF_PK_MIX 16'h8134
`define BLD_OFF_PK_PCNT 16'h8148
`define BLD_WIN_LO 20'ha0000
`define BLD_WIN_HI 20'ha7fff

// -----------------------------------------------------------------
// indexed register, command and mix fields
// -----------------------------------------------------------------
`define BLD_IDX_TOP 4'h1
`define BLD_IDX_LEFT 4'h2
`define BLD_IDX_BOT 4'h3
`define BLD_IDX_RIGHT 4'h4
`define BLD_IDX_PIXCTL 4'ha
`define BLD_IDX_MISC 4'he
`define BLD_MISC_EXTCLIP 5
`define BLD_MISC_CMP_POL 7
`define BLD_MISC_CMP_EN 8
`define BLD_PIXCTL_FG 12'h000
`define BLD_CMD_YPOS 7
`define BLD_CMD_YMAJ 6
`define BLD_CMD_XPOS 5
`define BLD_CMD_DRAW 4
`define BLD_CMD_OP_LINE 4'h2
`define BLD_STAT_BUSY 9
`define BLD_SRC_BG 2'h0
`define BLD_SRC_FG 2'h1
`define BLD_SRC_CPU 2'h2
`define BLD_MIX_NEW 4'h7
`define BLD_MIX_XOR 4'h5

// -----------------------------------------------------------------
// reset values and fifo size
// -----------------------------------------------------------------
`define BLD_RST_ZERO 16'h0000
`define BLD_RST_WMASK 16'hffff
`define BLD_RST_MIX 16'h0027
`define BLD_RST_CLIP_MAX 12'hfff
`define BLD_FIFO_DEPTH 16
`define BLD_FIFO_WIDTH 16

`endif

// ### pkg/bld_pkg.sv
// types shared by the line draw engine and its testbench
// assumes nothing beyond the params header
package bld_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_COLOUR = 3'b001,
		ST_READ = 3'b010,
		ST_WAIT = 3'b011,
		ST_STEP = 3'b100
	} bld_state_type;

	typedef struct packed {
		logic [15:0] addr;
		logic wr;
		logic rd;
		logic wide;
		logic [31:0] wdata;
	} bld_reg_req_type;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [15:0] x;
		logic [15:0] y;
		logic [7:0] data;
		logic [7:0] mask;
	} bld_fb_req_type;

	typedef struct packed {
		logic [15:0] cur_x;
		logic [15:0] cur_y;
		logic [15:0] axstp;
		logic [15:0] dgstp;
		logic [15:0] err;
		logic [15:0] pcnt;
		logic [15:0] cmd;
		logic [15:0] bg_col;
		logic [15:0] fg_col;
		logic [15:0] wmask;
		logic [15:0] cmp;
		logic [15:0] bg_mix;
		logic [15:0] fg_mix;
		logic [11:0] clip_t;
		logic [11:0] clip_l;
		logic [11:0] clip_b;
		logic [11:0] clip_r;
		logic [11:0] pixctl;
		logic [11:0] misc;
	} bld_regs_type;

endpackage

// ### rtl/bld_fifo.sv
// flip-flop fifo for cpu pixel data ahead of the engine
// assumes depth is a power of two; single clock, synchronous reset
`timescale 1ns/10ps
`default_nettype none
`include "bld_params.svh"

module bld_fifo #(
	parameter int WIDTH = `BLD_FIFO_WIDTH,
	parameter int DEPTH = `BLD_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);

	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [CW-1:0] cnt;
		logic nfull;
	} bld_fifo_state_type;

	bld_fifo_state_type q;
	bld_fifo_state_type d;
	logic push;
	logic pop;

	// -----------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------
	always_comb begin
		d = q;
		push = in_valid && q.nfull;
		pop = out_ready && (q.cnt != '0);
		if (push) begin
			d.mem[q.wp] = in_data;
			d.wp = q.wp + 1'b1;
		end
		if (pop) begin
			d.rp = q.rp + 1'b1;
		end
		if (push && !pop) begin
			d.cnt = q.cnt + 1'b1;
		end else if (pop && !push) begin
			d.cnt = q.cnt - 1'b1;
		end
		// ready is registered so the source sees a clean level
		d.nfull = (d.cnt != CW'(DEPTH));
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			q <= '0;
			q.nfull <= 1'b1;
		end else if (ce) begin
			q <= d;
		end
	end

	assign in_ready = q.nfull;
	assign out_valid = (q.cnt != '0);
	assign out_data = q.mem[q.rp];

endmodule
`default_nettype wire

// ### dv/bld_engine_asserts.sv
// checker for the line draw engine top-level ports
// assumes a bind from the bench top; one clock, sync reset active low
`timescale 1ns/10ps
`default_nettype none
`include "bld_params.svh"

module bld_engine_asserts (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire bld_pkg::bld_reg_req_type reg_req,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic mem_wr,
	input wire logic [19:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	input wire logic pix_ready,
	input wire bld_pkg::bld_fb_req_type fb_req,
	input wire logic fb_rd_valid,
	input wire logic [7:0] fb_rd_data,
	input wire logic busy
);
	logic start;
	logic draw_q;
	assign start = ce && reg_req.wr && !reg_req.wide && !busy
		&& reg_req.addr == `BLD_OFF_CMD && reg_req.wdata[15:13] == 3'b001
		&& !reg_req.wdata[11] && reg_req.wdata[0];
	// draw bit kept so move-only runs are told apart
	always_ff @(posedge clk) begin
		if (start) begin
			draw_q <= reg_req.wdata[`BLD_CMD_DRAW];
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// ---------------------------------------------
	// properties
	// ---------------------------------------------
	cmd_start_a: assert property (start |=> busy)
		else $error("command did not start");
	move_no_fb_a: assert property (busy && !draw_q |-> !fb_req.rd && !fb_req.wr)
		else $error("move-only run touched the frame buffer");
	wr_after_rd_a: assert property (fb_req.wr |-> $past(fb_rd_valid))
		else $error("pixel written without a read answer");
	same_pixel_a: assert property (fb_req.wr |-> $stable(fb_req.x) && $stable(fb_req.y))
		else $error("write went to another pixel");
	rd_pulse_a: assert property (fb_req.rd |=> !fb_req.rd)
		else $error("frame read longer than one cycle");
	wr_pulse_a: assert property (fb_req.wr |=> !fb_req.wr)
		else $error("frame write longer than one cycle");
	fb_busy_a: assert property (fb_req.rd || fb_req.wr |-> busy)
		else $error("frame traffic while idle");
	rd_answer_a: assert property (ce && reg_req.rd |=> reg_rvalid)
		else $error("register read not answered");
	reset_idle_a: assert property ($rose(resetn) |-> pix_ready && !busy)
		else $error("not idle after reset");
endmodule
`default_nettype wire

// ### dv/tb_bld_engine.sv
// self-checking bench for the line draw engine
// assumes bld_pkg and the design compiled first; ce held high except during one register write
`timescale 1ns/10ps
`default_nettype none
`include "bld_params.svh"

module tb_bld_engine;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic ce = 1'b1;
	bld_pkg::bld_reg_req_type reg_req = '0;
	logic [15:0] reg_rdata;
	logic reg_rvalid, pix_ready, busy;
	logic mem_wr = 1'b0;
	logic [19:0] mem_addr = 20'h00000;
	logic [15:0] mem_wdata = 16'h0000;
	bld_pkg::bld_fb_req_type fb_req;
	logic fb_rd_valid = 1'b0;
	logic [7:0] fb_rd_data = 8'h00;
	int error_cnt = 0;
	int cmp_count = 0;
	logic [7:0] fbm [256];
	logic [7:0] ref_m [256];
	logic [7:0] a;
	logic [15:0] q [$];
	logic [15:0] fm, bm, fc, bc, wm, cv, d;
	logic [11:0] misc;
	bit pc;
	int ct, cl, cb, cr;
	bld_engine dut (.clk(clk), .resetn(resetn), .ce(ce), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .mem_wr(mem_wr),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .pix_ready(pix_ready),
		.fb_req(fb_req), .fb_rd_valid(fb_rd_valid), .fb_rd_data(fb_rd_data),
		.busy(busy));
	always #50 clk = ~clk;
	// ---------------------------------------------
	// frame buffer: answers each read after 0..2 idle cycles
	// ---------------------------------------------
	always @(posedge clk) begin
		if (fb_req.wr === 1'b1) begin
			// planes outside the mask keep what the memory holds
			fbm[{fb_req.y[3:0], fb_req.x[3:0]}] <= (fb_req.data & fb_req.mask)
				| (fbm[{fb_req.y[3:0], fb_req.x[3:0]}] & ~fb_req.mask);
		end
	end
	initial forever begin
		@(posedge clk);
		if (fb_req.rd === 1'b1) begin
			a = {fb_req.y[3:0], fb_req.x[3:0]};
			repeat ($urandom_range(2, 0)) @(posedge clk);
			fb_rd_data <= fbm[a];
			fb_rd_valid <= 1'b1;
			@(posedge clk);
			fb_rd_valid <= 1'b0;
			fb_rd_data <= ~fbm[a];
		end
	end
	// ---------------------------------------------
	// tasks
	// ---------------------------------------------
	task automatic check(input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [15:0] ad, input logic [31:0] v, input bit w);
		@(posedge clk);
		reg_req <= '{addr: ad, wr: 1'b1, rd: 1'b0, wide: w, wdata: v};
		@(posedge clk);
		reg_req <= '0;
		#1;
	endtask
	task automatic w16(input logic [15:0] ad, input logic [15:0] v);
		wr(ad, {16'h0, v}, 1'b0);
	endtask
	task automatic rd(input logic [15:0] ad);
		@(posedge clk);
		reg_req <= '{addr: ad, wr: 1'b0, rd: 1'b1, wide: 1'b0, wdata: 32'h0};
		@(posedge clk);
		reg_req <= '0;
		#1;
		check(reg_rvalid, 1'b1);
		d = reg_rdata;
	endtask
	task automatic mem(input logic [19:0] ad, input logic [15:0] w);
		@(posedge clk);
		mem_wr <= 1'b1;
		mem_addr <= ad;
		mem_wdata <= w;
		@(posedge clk);
		mem_wr <= 1'b0;
		#1;
	endtask
	task automatic push(input logic [15:0] w);
		case ($urandom_range(2, 0))
			0: w16(`BLD_OFF_PIX0, w);
			1: w16(`BLD_OFF_PIX1, w);
			default: mem(`BLD_WIN_LO + 20'($urandom_range(32'h7fff, 0)), w);
		endcase
		q.push_back(w);
	endtask
	function automatic logic [15:0] rmix();
		return {9'h0, 2'($urandom), 1'b0, 1'($urandom) ? `BLD_MIX_NEW : `BLD_MIX_XOR};
	endfunction
	task automatic apply();
		wr(`BLD_OFF_PK_MIX, {fm, bm}, 1'b1);
		w16(`BLD_OFF_FG_COL, fc);
		w16(`BLD_OFF_BG_COL, bc);
		w16(`BLD_OFF_WMASK, wm);
		w16(`BLD_OFF_CMP, cv);
		w16(`BLD_OFF_MULTI, {4'he, misc});
		w16(`BLD_OFF_MULTI, {4'ha, pc ? 12'h080 : `BLD_PIXCTL_FG});
		w16(`BLD_OFF_MULTI, {4'h1, 12'(ct)});
		w16(`BLD_OFF_MULTI, {4'h2, 12'(cl)});
		w16(`BLD_OFF_MULTI, {4'h3, 12'(cb)});
		w16(`BLD_OFF_MULTI, {4'h4, 12'(cr)});
	endtask
	// expected pixel after clip, compare, mix and plane mask
	function automatic void pix(int x, int y, logic [15:0] c);
		logic [7:0] o, n;
		o = ref_m[{y[3:0], x[3:0]}];
		if ((x >= cl && x <= cr && y >= ct && y <= cb) == misc[5]) return;
		if (misc[8] && ((o == cv[7:0]) != misc[7])) return;
		n = (pc ? bm[3:0] : fm[3:0]) == `BLD_MIX_XOR ? o ^ c[7:0] : c[7:0];
		ref_m[{y[3:0], x[3:0]}] = (o & ~wm[7:0]) | (n & wm[7:0]);
	endfunction
	task automatic line(input int x1, input int y1, input int x2, input int y2,
		input bit dr);
		int dx, dy, sx, sy, mx, mn, e, x, y, k;
		logic [1:0] s;
		// a zero-length line would load a count of ffff
		if (x2 == x1 && y2 == y1) x2 = x1 ^ 1;
		dx = x2 - x1;
		dy = y2 - y1;
		sx = dx < 0 ? -1 : 1;
		sy = dy < 0 ? -1 : 1;
		dx = dx * sx;
		dy = dy * sy;
		mx = dx > dy ? dx : dy;
		mn = dx > dy ? dy : dx;
		e = 2 * mn - mx - int'(sx < 0);
		s = pc ? bm[6:5] : fm[6:5];
		if ($urandom_range(1, 0)) begin
			wr(`BLD_OFF_PK_POS, {16'(x1), 16'(y1)}, 1'b1);
			wr(`BLD_OFF_PK_PCNT, {16'(mx - 1), 16'h0}, 1'b1);
			wr(`BLD_OFF_PK_STEP, {16'(2 * (mn - mx)), 16'(2 * mn)}, 1'b1);
		end else begin
			w16(`BLD_OFF_CUR_X, 16'(x1));
			w16(`BLD_OFF_CUR_Y, 16'(y1));
			w16(`BLD_OFF_PCNT, 16'(mx - 1));
			w16(`BLD_OFF_AXSTP, 16'(2 * mn));
			w16(`BLD_OFF_DGSTP, 16'(2 * (mn - mx)));
		end
		w16(`BLD_OFF_ERR, 16'(e));
		while (dr && s == `BLD_SRC_CPU && q.size() < mx) push(16'($urandom));
		d = 16'h2001 | {8'h0, sy > 0, dy > dx, sx > 0, dr, 4'h0};
		w16(`BLD_OFF_CMD, d);
		if (dr && mx > 7) begin
			w16(`BLD_OFF_CMD, d ^ 16'h0080); // refused: engine is busy
			rd(`BLD_OFF_CMD);
			check(d[`BLD_STAT_BUSY], 1'b1);
		end
		for (k = 0; k < 4000 && busy !== 1'b0; k++) begin
			@(posedge clk);
			#1;
		end
		check(busy, 1'b0);
		x = x1;
		y = y1;
		for (k = 0; k < mx; k++) begin
			if (k > 0) begin
				if (dy > dx) y += sy; else x += sx;
				if (e >= 0) begin
					if (dy > dx) x += sx; else y += sy;
					e += 2 * (mn - mx);
				end else e += 2 * mn;
			end
			if (dr) pix(x, y, s == `BLD_SRC_CPU ? q.pop_front() : s == `BLD_SRC_BG ? bc : fc);
		end
		for (k = 0; k < 256; k++) check(fbm[k], ref_m[k]);
		rd(`BLD_OFF_CUR_X);
		check(d, 16'(x));
		rd(`BLD_OFF_CUR_Y);
		check(d, 16'(y));
		rd(`BLD_OFF_FG_MIX);
		check(d, fm);
	endtask
	task automatic test_done();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clk);
		error_cnt++;
		test_done();
	end
	initial begin
		void'($urandom(32'h46e09b3d));
		for (int k = 0; k < 256; k++) begin
			fbm[k] = 8'($urandom_range(3, 0));
			ref_m[k] = fbm[k];
		end
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		rd(`BLD_OFF_WMASK);
		check(d, `BLD_RST_WMASK);
		rd(`BLD_OFF_BG_MIX);
		check(d, `BLD_RST_MIX);
		rd(16'h1234);
		check(d, 16'h0000);
		wr(`BLD_OFF_PK_POS, {16'h0007, 16'h0003}, 1'b1);
		rd(`BLD_OFF_CUR_Y);
		check(d, 16'h0003);
		rd(`BLD_OFF_CUR_X);
		check(d, 16'h0007);
		// clock enable low: the write must leave no trace
		@(posedge clk);
		ce <= 1'b0;
		w16(`BLD_OFF_CMP, 16'h00ff);
		@(posedge clk);
		ce <= 1'b1;
		rd(`BLD_OFF_CMP);
		check(d, `BLD_RST_ZERO);
		$display("registers done");
		fm = 16'h0047;
		{bm, fc, bc, cv, wm, misc, pc} = {16'h0027, 16'h8, 16'h0, 16'h0, 16'hffff, 12'h0, 1'b0};
		{ct, cl, cb, cr} = {32'd0, 32'd0, 32'd15, 32'd15};
		apply();
		repeat (16) push(16'($urandom));
		check(pix_ready, 1'b0);
		w16(`BLD_OFF_PIX0, 16'h00aa);
		line(0, 0, 15, 5, 1'b1);
		check(pix_ready, 1'b1);
		mem(20'ha8000, 16'h0055);
		line(5, 5, 6, 6, 1'b1);
		line(2, 14, 13, 3, 1'b0);
		$display("corners done");
		for (int i = 0; i < 30; i++) begin
			if ($urandom_range(2, 0) != 0) begin
				{fm, bm, fc, bc} = {rmix(), rmix(), 16'($urandom % 256), 16'($urandom % 256)};
				wm = 1'($urandom) ? 16'hffff : 16'($urandom % 256);
				cv = 16'($urandom_range(3, 0));
				misc = {3'h0, $urandom_range(3, 0) == 0, 1'($urandom), 1'b0, 1'($urandom), 5'h0};
				pc = $urandom_range(3, 0) == 0;
				{ct, cl, cb, cr} = {$urandom % 5, $urandom % 5, 10 + $urandom % 6, 10 + $urandom % 6};
				apply();
			end
			line($urandom % 16, $urandom % 16, $urandom % 15 + 1, $urandom % 16, $urandom % 6 != 0);
			$display("test %0d done", i);
		end
		test_done();
	end
endmodule

bind bld_engine bld_engine_asserts chk (.clk(clk), .resetn(resetn), .ce(ce),
	.reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
	.pix_ready(pix_ready), .fb_req(fb_req), .fb_rd_valid(fb_rd_valid),
	.fb_rd_data(fb_rd_data), .busy(busy));
`default_nettype wire
